// File: timing_logic_defines.svh
// Register offsets, field positions, reset values and timing counts of the timing logic.
`ifndef TIMING_LOGIC_DEFINES_SVH
`define TIMING_LOGIC_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define OFS_CONFIG       8'h00
`define OFS_DELAY        8'h04
`define OFS_HOLD         8'h08
`define OFS_STATUS       8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_MODE_LSB     0
`define CFG_MODE_MSB     3
`define CFG_NC_BIT       4
`define CFG_INV_BIT      5
`define CFG_RANGE_LSB    6
`define CFG_RANGE_MSB    7
`define STS_OUT_BIT      0
`define STS_IN_BIT       1
`define STS_INH_BIT      2
`define STS_STATE_LSB    3
`define STS_STATE_MSB    7

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CONFIG       8'h00
`define RST_SETTING      8'h0A

// ****************************************************************
// Timing: setting span in ticks, clock and base tick
// ****************************************************************
`define SETTING_MIN      8'h0A
`define SETTING_MAX      8'h96
`define CLK_PERIOD_NS    8
`define TICK_BASE_NS     1000000
`define TICK_BASE_CYCLES (`TICK_BASE_NS / `CLK_PERIOD_NS)
`define RANGE_SCALE_0    1
`define RANGE_SCALE_1    10
`define RANGE_SCALE_2    100

`endif

// File: timing_logic_pkg.sv
// Types shared by the timing logic modules.
package timing_logic_pkg;

   // ****************************************************************
   // Timing functions selectable by software
   // ****************************************************************
   typedef enum logic [3:0] {
      MODE_FOLLOW    = 4'h0,
      MODE_ON_DLY    = 4'h1,
      MODE_OFF_DLY   = 4'h2,
      MODE_ON_OFF    = 4'h3,
      MODE_ONE_SHOT  = 4'h4,
      MODE_DLY_SHOT  = 4'h5,
      MODE_LIMIT     = 4'h6,
      MODE_REPEAT    = 4'h7,
      MODE_EDGE_LAT  = 4'h8,
      MODE_LEVEL_LAT = 4'h9,
      MODE_DLY_LAT   = 4'hA,
      MODE_LIM_LAT   = 4'hB
   } mode_e;

   // ****************************************************************
   // Sequencer states, one-hot
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_DELAY = 5'h02,
      ST_ON    = 5'h04,
      ST_HOLD  = 5'h08,
      ST_LATCH = 5'h10
   } state_e;

endpackage : timing_logic_pkg

// File: tick_if.sv
// Carrier between the sequencer and the range prescaler.
`timescale 1ns/1ps
interface tick_if;
   logic [1:0] rangeSel;
   logic       clr;
   logic       tick;

   modport gen  (input rangeSel, input clr, output tick);
   modport user (output rangeSel, output clr, input tick);
endinterface : tick_if

// File: range_prescaler.sv
// Prescaler that turns the clock into a timing tick for the selected range.
`timescale 1ns/1ps
`include "timing_logic_defines.svh"
module range_prescaler #(
   parameter int BASE_CYCLES = `TICK_BASE_CYCLES,
   parameter int CNT_W       = 24
) (
   input wire logic clk,
   input wire logic rst_n,
   tick_if.gen      tk
);

   logic [CNT_W-1:0] div;

   // Last divider count (cycles per tick less one) for a range; the unused range code maps to the slowest.
   function automatic logic [CNT_W-1:0] tickLimit(input logic [1:0] sel);
      int prod;
      case (sel)
         2'h0:    prod = BASE_CYCLES * `RANGE_SCALE_0;
         2'h1:    prod = BASE_CYCLES * `RANGE_SCALE_1;
         default: prod = BASE_CYCLES * `RANGE_SCALE_2;
      endcase
      return CNT_W'(prod - 1);
   endfunction : tickLimit

   // Clearing with the timer keeps the first tick a full period away, so no time is lost to phase.
   always_ff @(posedge clk) begin
      if (!rst_n || tk.clr) begin
         div     <= '0;
         tk.tick <= 1'b0;
      end else if (div >= tickLimit(tk.rangeSel)) begin
         div     <= '0;
         tk.tick <= 1'b1;
      end else begin
         div     <= div + CNT_W'(1);
         tk.tick <= 1'b0;
      end
   end

endmodule : range_prescaler

// File: multi_mode_timing_logic.sv
// Multi-function timing logic: sensed input and inhibit in, one on/off output out.
//
// Behaviour
// - Follow mode: output tracks qualified input.
// - Follow mode: inhibit forces output off.
// - On delay: output after continuous input delay.
// - On delay: input gap clears delay timer.
// - On delay: inhibit cancels; restart if input.
// - Off delay: on at once, hold after removal.
// - Off delay: inhibit blocks start, hold finishes.
// - Combined: inhibit clears delay, hold finishes.
// - Delay and hold set independently.
// - One-shot: hold pulse on input edge.
// - One-shot: inhibit blocks triggers, not pulse.
// - Delayed one-shot: delay, pulse, needs re-edge.
// - Delayed one-shot: inhibit aborts delay only.
// - Limit: follow input, cut after hold.
// - Limit: inhibit cancels; restart after release.
// - Repeat: alternate delay off, hold on.
// - Repeat: inhibit stops cycling, hold completes.
// - Edge latch: set on edge, inhibit clears.
// - Level latch: set by level, inhibit off.
// - Delay latch: latch after continuous delay.
// - Delay latch: inhibit clears latch and timer.
// - Limit latch: timer cleared only by inhibit.
// - Function selector plus open/closed output sense.
// - Three ranges shared by delay and hold.
`timescale 1ns/1ps
`include "timing_logic_defines.svh"
module multi_mode_timing_logic #(
   parameter int BASE_TICK_CYCLES = `TICK_BASE_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       sensorIn,
   input  wire logic       auxInN,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdata,
   output logic            outPin
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic                        sensorSync1;
   logic                        sensorSync2;
   logic                        auxSync1;
   logic                        auxSync2;
   logic                        inAct;
   logic                        inPrev;
   logic                        inRise;
   logic                        inh;
   logic [7:0]                  cfgReg;
   logic [7:0]                  delaySet;
   logic [7:0]                  holdSet;
   logic                        cfgWrite;
   timing_logic_pkg::mode_e     mode;
   timing_logic_pkg::state_e    state;
   timing_logic_pkg::state_e    next_state;
   logic [7:0]                  cnt;
   logic [7:0]                  target;
   logic                        timerDone;
   logic                        cntEn;
   logic                        cntClear;
   logic                        outActive;
   logic                        next_outActive;
   tick_if                      tk ();

   // Clamp a setting into the adjustable span of a range.
   function automatic logic [7:0] clampSetting(input logic [7:0] v);
      if (v < `SETTING_MIN) begin
         return `SETTING_MIN;
      end else if (v > `SETTING_MAX) begin
         return `SETTING_MAX;
      end else begin
         return v;
      end
   endfunction : clampSetting

   // ****************************************************************
   // Input qualification
   // ****************************************************************

   // Both pins are asynchronous, so each passes two flip-flops before use.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sensorSync1 <= 1'b0;
         sensorSync2 <= 1'b0;
         auxSync1    <= 1'b1;
         auxSync2    <= 1'b1;
      end else begin
         sensorSync1 <= sensorIn;
         sensorSync2 <= sensorSync1;
         auxSync1    <= auxInN;
         auxSync2    <= auxSync1;
      end
   end

   // Polarity is applied before the edge detector, so an inverted sense triggers on the opposite edge.
   assign inAct  = sensorSync2 ^ cfgReg[`CFG_INV_BIT];
   assign inh    = ~auxSync2;
   assign inRise = inAct & ~inPrev;

   // Previous qualified level for edge detection; starts high, yet the sensor synchronisers reset low, so a level present at reset gives an edge once it passes them.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         inPrev <= 1'b1;
      end else begin
         inPrev <= inAct;
      end
   end

   // ****************************************************************
   // Register port
   // ****************************************************************
   assign cfgWrite = regWr && (regAddr == `OFS_CONFIG);
   assign mode     = timing_logic_pkg::mode_e'(cfgReg[`CFG_MODE_MSB:`CFG_MODE_LSB]);

   // Software settings; delay and hold are separate registers sharing one range.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfgReg   <= `RST_CONFIG;
         delaySet <= `RST_SETTING;
         holdSet  <= `RST_SETTING;
      end else if (regWr) begin
         case (regAddr)
            `OFS_CONFIG: cfgReg <= regWdata;
            `OFS_DELAY:  delaySet <= regWdata;
            `OFS_HOLD:   holdSet <= regWdata;
            default:     cfgReg <= cfgReg;
         endcase
      end
   end

   // Read data stand for exactly one cycle after the strobe; unmapped offsets read zero.
   always_ff @(posedge clk) begin
      if (!rst_n || !regRd) begin
         regRdata <= 8'h00;
      end else begin
         case (regAddr)
            `OFS_CONFIG: regRdata <= cfgReg;
            `OFS_DELAY:  regRdata <= delaySet;
            `OFS_HOLD:   regRdata <= holdSet;
            `OFS_STATUS: regRdata <= {state, inh, inAct, outActive};
            default:     regRdata <= 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // Time base and timer
   // ****************************************************************
   assign tk.rangeSel = cfgReg[`CFG_RANGE_MSB:`CFG_RANGE_LSB];
   assign tk.clr      = cntClear;

   range_prescaler #(
      .BASE_CYCLES (BASE_TICK_CYCLES),
      .CNT_W       (24)
   ) u_prescaler (
      .clk   (clk),
      .rst_n (rst_n),
      .tk    (tk)
   );

   // The delay phase uses the delay setting, every other phase the hold setting.
   assign target    = (state == timing_logic_pkg::ST_DELAY) ? clampSetting(delaySet)
                                                            : clampSetting(holdSet);
   assign timerDone = (cnt >= target);

   // The timer restarts on every state change; limit-and-latch pauses it while the input is away.
   assign cntClear = cfgWrite || (next_state != state) || (state == timing_logic_pkg::ST_IDLE);
   assign cntEn    = (mode != timing_logic_pkg::MODE_LIM_LAT) || inAct;

   // Tick counter, saturating so a long wait never wraps into a false expiry.
   always_ff @(posedge clk) begin
      if (!rst_n || cntClear) begin
         cnt <= 8'h00;
      end else if (tk.tick && cntEn && !timerDone) begin
         cnt <= cnt + 8'h01;
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************

   // One next-state table per group of functions; follow mode and an undefined function code rest idle.
   always_comb begin
      next_state = state;
      case (mode)
         timing_logic_pkg::MODE_ON_DLY, timing_logic_pkg::MODE_ON_OFF: begin
            case (state)
               timing_logic_pkg::ST_IDLE: begin
                  if (inAct && !inh) next_state = timing_logic_pkg::ST_DELAY;
               end
               timing_logic_pkg::ST_DELAY: begin
                  if (!inAct || inh) next_state = timing_logic_pkg::ST_IDLE;
                  else if (timerDone) next_state = timing_logic_pkg::ST_ON;
               end
               timing_logic_pkg::ST_ON: begin
                  if (mode == timing_logic_pkg::MODE_ON_DLY) begin
                     if (!inAct || inh) next_state = timing_logic_pkg::ST_IDLE;
                  end else if (!inAct || inh) begin
                     next_state = timing_logic_pkg::ST_HOLD;
                  end
               end
               timing_logic_pkg::ST_HOLD: begin
                  if (inAct && !inh) next_state = timing_logic_pkg::ST_ON;
                  else if (timerDone) next_state = timing_logic_pkg::ST_IDLE;
               end
               default: next_state = timing_logic_pkg::ST_IDLE;
            endcase
         end
         timing_logic_pkg::MODE_OFF_DLY: begin
            case (state)
               timing_logic_pkg::ST_IDLE: begin
                  if (inAct && !inh) next_state = timing_logic_pkg::ST_ON;
               end
               timing_logic_pkg::ST_ON: begin
                  if (!inAct || inh) next_state = timing_logic_pkg::ST_HOLD;
               end
               timing_logic_pkg::ST_HOLD: begin
                  if (inAct && !inh) next_state = timing_logic_pkg::ST_ON;
                  else if (timerDone) next_state = timing_logic_pkg::ST_IDLE;
               end
               default: next_state = timing_logic_pkg::ST_IDLE;
            endcase
         end
         timing_logic_pkg::MODE_ONE_SHOT, timing_logic_pkg::MODE_DLY_SHOT: begin
            case (state)
               timing_logic_pkg::ST_IDLE: begin
                  if (inRise && !inh) begin
                     next_state = (mode == timing_logic_pkg::MODE_ONE_SHOT) ? timing_logic_pkg::ST_HOLD
                                                                           : timing_logic_pkg::ST_DELAY;
                  end
               end
               timing_logic_pkg::ST_DELAY: begin
                  if (inh) next_state = timing_logic_pkg::ST_IDLE;
                  else if (timerDone) next_state = timing_logic_pkg::ST_HOLD;
               end
               timing_logic_pkg::ST_HOLD: begin
                  if (timerDone) next_state = timing_logic_pkg::ST_IDLE;
               end
               default: next_state = timing_logic_pkg::ST_IDLE;
            endcase
         end
         timing_logic_pkg::MODE_LIMIT, timing_logic_pkg::MODE_LIM_LAT: begin
            case (state)
               timing_logic_pkg::ST_IDLE: begin
                  if (inAct && !inh) next_state = timing_logic_pkg::ST_ON;
               end
               timing_logic_pkg::ST_ON: begin
                  if (inh) next_state = timing_logic_pkg::ST_IDLE;
                  else if (!inAct && mode == timing_logic_pkg::MODE_LIMIT) next_state = timing_logic_pkg::ST_IDLE;
                  else if (timerDone) next_state = timing_logic_pkg::ST_LATCH;
               end
               timing_logic_pkg::ST_LATCH: begin
                  if (inh) next_state = timing_logic_pkg::ST_IDLE;
                  else if (!inAct && mode == timing_logic_pkg::MODE_LIMIT) next_state = timing_logic_pkg::ST_IDLE;
               end
               default: next_state = timing_logic_pkg::ST_IDLE;
            endcase
         end
         timing_logic_pkg::MODE_REPEAT: begin
            case (state)
               timing_logic_pkg::ST_IDLE: begin
                  if (inAct && !inh) next_state = timing_logic_pkg::ST_DELAY;
               end
               timing_logic_pkg::ST_DELAY: begin
                  if (!inAct || inh) next_state = timing_logic_pkg::ST_IDLE;
                  else if (timerDone) next_state = timing_logic_pkg::ST_HOLD;
               end
               timing_logic_pkg::ST_HOLD: begin
                  if (timerDone) begin
                     next_state = (inAct && !inh) ? timing_logic_pkg::ST_DELAY
                                                  : timing_logic_pkg::ST_IDLE;
                  end
               end
               default: next_state = timing_logic_pkg::ST_IDLE;
            endcase
         end
         timing_logic_pkg::MODE_EDGE_LAT, timing_logic_pkg::MODE_LEVEL_LAT, timing_logic_pkg::MODE_DLY_LAT: begin
            case (state)
               timing_logic_pkg::ST_IDLE: begin
                  if (!inh) begin
                     if (mode == timing_logic_pkg::MODE_EDGE_LAT && inRise) next_state = timing_logic_pkg::ST_LATCH;
                     if (mode == timing_logic_pkg::MODE_LEVEL_LAT && inAct) next_state = timing_logic_pkg::ST_LATCH;
                     if (mode == timing_logic_pkg::MODE_DLY_LAT && inAct) next_state = timing_logic_pkg::ST_DELAY;
                  end
               end
               timing_logic_pkg::ST_DELAY: begin
                  if (!inAct || inh) next_state = timing_logic_pkg::ST_IDLE;
                  else if (timerDone) next_state = timing_logic_pkg::ST_LATCH;
               end
               timing_logic_pkg::ST_LATCH: begin
                  if (inh) next_state = timing_logic_pkg::ST_IDLE;
               end
               default: next_state = timing_logic_pkg::ST_IDLE;
            endcase
         end
         default: next_state = timing_logic_pkg::ST_IDLE;
      endcase
   end

   // A function change drops any sequence in flight rather than reinterpret its state.
   always_ff @(posedge clk) begin
      if (!rst_n || cfgWrite) begin
         state <= timing_logic_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Output
   // ****************************************************************

   // Output decode is taken from the next state so the output moves with the state change.
   always_comb begin
      next_outActive = 1'b0;
      case (mode)
         timing_logic_pkg::MODE_FOLLOW:    next_outActive = inAct && !inh;
         timing_logic_pkg::MODE_ON_DLY:    next_outActive = (next_state == timing_logic_pkg::ST_ON);
         timing_logic_pkg::MODE_OFF_DLY,
         timing_logic_pkg::MODE_ON_OFF:    next_outActive = (next_state == timing_logic_pkg::ST_ON) ||
                                                            (next_state == timing_logic_pkg::ST_HOLD);
         timing_logic_pkg::MODE_ONE_SHOT,
         timing_logic_pkg::MODE_DLY_SHOT,
         timing_logic_pkg::MODE_REPEAT:    next_outActive = (next_state == timing_logic_pkg::ST_HOLD);
         timing_logic_pkg::MODE_LIMIT:     next_outActive = (next_state == timing_logic_pkg::ST_ON);
         timing_logic_pkg::MODE_LIM_LAT:   next_outActive = (next_state == timing_logic_pkg::ST_ON) && inAct;
         timing_logic_pkg::MODE_EDGE_LAT,
         timing_logic_pkg::MODE_LEVEL_LAT,
         timing_logic_pkg::MODE_DLY_LAT:   next_outActive = (next_state == timing_logic_pkg::ST_LATCH);
         default:                          next_outActive = 1'b0;
      endcase
   end

   // Reset forces the output off so power-up never produces a false output.
   always_ff @(posedge clk) begin
      if (!rst_n || cfgWrite) begin
         outActive <= 1'b0;
      end else begin
         outActive <= next_outActive;
      end
   end

   // Normally-closed sense inverts the pin; during reset the pin is low.
   // A function change shows the inactive level at once, so the pin never carries the old function's output.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outPin <= 1'b0;
      end else if (cfgWrite) begin
         outPin <= regWdata[`CFG_NC_BIT];
      end else begin
         outPin <= next_outActive ^ cfgReg[`CFG_NC_BIT];
      end
   end

endmodule : multi_mode_timing_logic

// File: sensor_model.sv
// Sensor and inhibit source at the far side of the timing logic.
`timescale 1ns/1ps
module sensor_model (
   input  wire logic clk,
   input  wire logic present,
   input  wire logic inhibit,
   input  wire logic darkOp,
   output logic      sensorIn,
   output logic      auxInN
);
   // A dark-operate sensor drives the inverse level; the inhibit contact pulls low.
   // Pins move just after an edge, as a contact settling between samples would.
   always @(posedge clk) begin
      sensorIn <= present ^ darkOp;
      auxInN   <= !inhibit;
   end
endmodule : sensor_model

// File: multi_mode_timing_logic_chk.sv
// Port checker of the timing logic.
`timescale 1ns/1ps
module multi_mode_timing_logic_chk (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       sensorIn,
   input wire logic       auxInN,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regRdata,
   input wire logic       outPin
);
   logic [7:0] cfg;
   logic       q;
   // Bus shadow of the configuration, so mode-dependent checks know the mode.
   always_ff @(posedge clk) begin
      if (!rst_n) cfg <= 8'h00;
      else if (regWr && regAddr == 8'h00) cfg <= regWdata;
   end
   assign q = (sensorIn ^ cfg[5]) && auxInN;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
      else $error("read data outside its slot");
   a_cfg_back: assert property (regWr && regAddr == 8'h00 ##1 !regWr ##1 regRd && regAddr == 8'h00
      |=> regRdata == $past(regWdata, 3)) else $error("config readback wrong");
   a_unmapped_zero: assert property (regRd && regAddr == 8'h10 |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_follow_on: assert property ((cfg[3:0] == 4'h0 && q) [*5] |-> outPin == !cfg[4])
      else $error("follow output not on");
   a_follow_off: assert property ((cfg[3:0] == 4'h0 && !(sensorIn ^ cfg[5])) [*5] |-> outPin == cfg[4])
      else $error("follow output not off");
   a_inhibit_off: assert property ((cfg[3:0] inside {0, 1, 6, 9, 10, 11} && !auxInN) [*5]
      |-> outPin == cfg[4]) else $error("inhibit did not force off");
   a_undef_off: assert property ((cfg[3:0] > 4'hB) [*3] |-> outPin == cfg[4])
      else $error("undefined mode drives output");
   a_ondly_cause: assert property (cfg[3:0] == 4'h1 && outPin != cfg[4]
      |-> $past(q, 5) && $past(q, 30)) else $error("on delay output without held input");
endmodule : multi_mode_timing_logic_chk
bind multi_mode_timing_logic multi_mode_timing_logic_chk i_multi_mode_timing_logic_chk (.clk, .rst_n,
   .sensorIn, .auxInN, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .outPin);

// File: test_multi_mode_timing_logic.sv
// Self-checking bench of the timing logic.
`timescale 1ns/1ps
module test_multi_mode_timing_logic;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       present = 1'b0;
   logic       inhibit = 1'b0;
   logic       darkOp = 1'b0;
   logic       nc = 1'b0;
   logic       sensorIn;
   logic       auxInN;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic       regWr = 1'b0;
   logic       regRd = 1'b0;
   logic [7:0] regRdata;
   logic       outPin;
   int         failures = 0;
   int         total_checks = 0;

   always #4 clk = ~clk;
   sensor_model i_sensor_model (.clk, .present, .inhibit, .darkOp, .sensorIn, .auxInN);
   // A 4-cycle base tick keeps the 15 s range inside a short run.
   multi_mode_timing_logic #(.BASE_TICK_CYCLES(4)) i_multi_mode_timing_logic (.clk, .rst_n, .sensorIn,
      .auxInN, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .outPin);

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask : tk
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Output is judged mid-cycle, after the edge's updates have landed.
   task automatic outIs(input logic e);
      @(negedge clk);
      cmp({7'h00, outPin}, {7'h00, e ^ nc});
   endtask : outIs
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {regAddr, regWdata, regWr} <= {a, d, 1'b1};
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rdIs(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      {regAddr, regRd} <= {a, 1'b1};
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      cmp(regRdata, e);
   endtask : rdIs
   task automatic setCfg(input logic [3:0] m, input logic [1:0] r);
      wr(8'h00, {r, darkOp, nc, m});
      rdIs(8'h00, {r, darkOp, nc, m});
   endtask : setCfg
   task automatic tRegs;
      rdIs(8'h04, 8'h0A);
      wr(8'h04, 8'h05);
      wr(8'h08, 8'hC8);
      rdIs(8'h04, 8'h05);
      rdIs(8'h08, 8'hC8);
      wr(8'h10, 8'hFF);
      rdIs(8'h10, 8'h00);
      wr(8'h08, 8'h0F);
   endtask : tRegs
   task automatic tFollow;
      for (int i = 0; i < 4; i++) begin
         {darkOp, nc} <= 2'(i);
         tk(1);
         setCfg(4'h0, 2'h0);
         present <= 1'b1;
         tk(6);
         outIs(1'b1);
         inhibit <= 1'b1;
         tk(6);
         outIs(1'b0);
         {inhibit, present} <= 2'b00;
         tk(6);
         outIs(1'b0);
      end
      {darkOp, nc} <= 2'b00;
      tk(1); // The next configuration must see the restored sense.
   endtask : tFollow
   // Delay of 10 ticks, broken once halfway, then inhibited and restarted.
   task automatic tOnDly(input int r, input int s);
      setCfg(4'h1, 2'(r));
      present <= 1'b1;
      tk(20 * s);
      present <= 1'b0;
      tk(4);
      present <= 1'b1;
      tk(40 * s - 6);
      outIs(1'b0);
      tk(14);
      outIs(1'b1);
      inhibit <= 1'b1;
      tk(6);
      outIs(1'b0);
      inhibit <= 1'b0;
      tk(30 * s);
      outIs(1'b0);
      tk(10 * s + 10);
      outIs(1'b1);
      present <= 1'b0;
   endtask : tOnDly
   // Short trigger gives a full 15-tick pulse; inhibit neither cuts it nor retriggers.
   task automatic tShot;
      setCfg(4'h4, 2'h0);
      present <= 1'b1;
      tk(3);
      present <= 1'b0;
      tk(4);
      outIs(1'b1);
      inhibit <= 1'b1;
      tk(45);
      outIs(1'b1);
      tk(16);
      outIs(1'b0);
      present <= 1'b1;
      tk(8);
      outIs(1'b0);
      {present, inhibit} <= 2'b00;
   endtask : tShot
   // Off delay, repeat cycle and delayed one-shot, with delay 10 and hold 15 ticks.
   task automatic tTimed;
      setCfg(4'h2, 2'h0);
      present <= 1'b1;
      tk(6);
      outIs(1'b1);
      inhibit <= 1'b1;
      tk(50);
      outIs(1'b1);
      tk(20);
      outIs(1'b0);
      {present, inhibit} <= 2'b00;
      tk(4);
      setCfg(4'h7, 2'h0);
      present <= 1'b1;
      tk(30);
      outIs(1'b0);
      tk(30);
      outIs(1'b1);
      tk(60);
      outIs(1'b0);
      tk(40);
      outIs(1'b1);
      present <= 1'b0;
      tk(40);
      outIs(1'b1);
      tk(60);
      outIs(1'b0);
      setCfg(4'h5, 2'h0);
      present <= 1'b1;
      tk(3);
      present <= 1'b0;
      tk(37);
      outIs(1'b0);
      tk(20);
      outIs(1'b1);
      inhibit <= 1'b1;
      tk(30);
      outIs(1'b1);
      tk(20);
      outIs(1'b0);
      inhibit <= 1'b0;
   endtask : tTimed
   task automatic tLatch;
      setCfg(4'h8, 2'h0);
      present <= 1'b1;
      tk(6);
      present <= 1'b0;
      tk(6);
      outIs(1'b1);
      {present, inhibit} <= 2'b11;
      tk(6);
      inhibit <= 1'b0;
      tk(6);
      outIs(1'b0);
      setCfg(4'h9, 2'h0);
      tk(6);
      outIs(1'b1);
      inhibit <= 1'b1;
      tk(6);
      inhibit <= 1'b0;
      tk(6);
      outIs(1'b1);
      setCfg(4'h6, 2'h0);
      tk(6);
      outIs(1'b1);
      tk(64);
      outIs(1'b0);
      setCfg(4'hC, 2'h0);
      tk(6);
      outIs(1'b0);
      present <= 1'b0;
   endtask : tLatch

   task automatic give_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // Watchdog: the sequence needs about 12000 cycles.
   initial begin
      #400us;
      failures++;
      give_verdict();
   end
   initial begin
      tk(5);
      rst_n <= 1'b1;
      tRegs();
      tFollow();
      tOnDly(0, 1);
      tOnDly(1, 10);
      tOnDly(2, 100);
      tShot();
      tTimed();
      tLatch();
      give_verdict();
   end
endmodule : test_multi_mode_timing_logic
